// File: hdl/user_time_stamp_processor.sv
// two user time stamp processors with an apb register slave
// How it works
// - 5-bit selector picks each processor's stamp source
// - config bit 7 picks the aux nco
// - stamps are elapsed time on assigned nco
// - results readable in two ten-byte ranges
// - conversion happens on each arriving stamp
// - conversion done sets status bit unless masked
// - missed counter counts lost stamps before current
// - reading missed counter clears it
// - off-period stamp sets error flag bit 0
// - result is 40.40 fixed point word
// - integer count equals one nco period
// - tag-only bit drops untagged stamps
// - update strobe refreshes time and missed count
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module user_time_stamp_processor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire tsp_pkg::stamp_bus_type stamps,
   input wire logic [tsp_pkg::TIME_W-1:0] nco0_time,
   input wire logic [tsp_pkg::TIME_W-1:0] nco1_time,
   output logic irq
);
   import tsp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // functions

   function automatic logic src_hit(proc_cfg_type c, stamp_bus_type b);
      logic h;
      h = 1'b0;
      if (c.sel < 5'(NUM_SRC)) begin
         h = b.valid[c.sel[3:0]] & (~c.tag_only | b.tag[c.sel[3:0]]);
      end
      return h;
   endfunction : src_hit

   function automatic logic map_hit(logic [13:0] i);
      logic h;
      h = 1'b0;
      if (i == IDX_UPDATE || i == IDX_CFG0 || i == IDX_CFG1) begin
         h = 1'b1;
      end else if (i == IDX_NOM0 || i == IDX_NOM1) begin
         h = 1'b1;
      end else if (i == IDX_STATUS || i == IDX_MASK) begin
         h = 1'b1;
      end else if (i >= IDX_TIME0 && i <= IDX_ERR0) begin
         h = 1'b1;
      end else if (i >= IDX_TIME1 && i <= IDX_ERR1) begin
         h = 1'b1;
      end
      return h;
   endfunction : map_hit

   function automatic logic [7:0] time_byte(logic [TIME_W-1:0] t, logic [13:0] off);
      logic [3:0] k;
      k = off[3:0];
      return t[{k, 3'b000} +: 8];
   endfunction : time_byte

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   logic [13:0] idx;
   logic acc_ph;
   logic wr_en;
   logic rd_en;
   logic hit;
   logic upd;
   logic [31:0] rd_data;

   assign idx = paddr[15:2];
   assign hit = map_hit(idx) & (paddr[1:0] == 2'b00);
   assign acc_ph = psel & penable;
   assign wr_en = acc_ph & pwrite & hit;
   assign rd_en = acc_ph & ~pwrite & hit;
   // zero wait states: every access completes in its first access cycle
   assign pready = acc_ph;
   assign pslverr = acc_ph & ~hit;
   assign upd = wr_en & (idx == IDX_UPDATE) & pwdata[UPDATE_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // configuration

   proc_cfg_type cfg_r [NUM_PROC];
   logic [NOM_W-1:0] nom_r [NUM_PROC];
   logic [7:0] mask_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r[0] <= CFG_RST;
         cfg_r[1] <= CFG_RST;
      end else if (wr_en && idx == IDX_CFG0) begin
         cfg_r[0] <= pwdata[7:0] & CFG_WMASK;
      end else if (wr_en && idx == IDX_CFG1) begin
         cfg_r[1] <= pwdata[7:0] & CFG_WMASK;
      end
   end

   // nominal stamp spacing in pclk cycles; zero leaves the period check off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nom_r[0] <= NOM_RST;
         nom_r[1] <= NOM_RST;
      end else if (wr_en && idx == IDX_NOM0) begin
         nom_r[0] <= pwdata[NOM_W-1:0];
      end else if (wr_en && idx == IDX_NOM1) begin
         nom_r[1] <= pwdata[NOM_W-1:0];
      end
   end

   // a set mask bit keeps its status bit from ever being raised
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_r <= STAT_RST;
      end else if (wr_en && idx == IDX_MASK) begin
         mask_r <= pwdata[7:0] & STAT_WMASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stamp acceptance and conversion

   logic [NUM_PROC-1:0] acc;
   logic [TIME_W-1:0] base_time [NUM_PROC];

   // selector codes above the last source never match
   always_comb begin
      for (int p = 0; p < NUM_PROC; p++) begin
         acc[p] = src_hit(cfg_r[p], stamps);
      end
   end

   // either processor may follow either nco
   always_comb begin
      for (int p = 0; p < NUM_PROC; p++) begin
         base_time[p] = cfg_r[p].tbase ? nco1_time : nco0_time;
      end
   end

   logic [TIME_W-1:0] live_time_r [NUM_PROC];
   logic [NUM_PROC-1:0] live_err_r;
   logic [NUM_PROC-1:0] seen_r;
   logic [NOM_W:0] gap_r [NUM_PROC];

   // cycles since last accepted stamp, saturating so a long pause still errors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int p = 0; p < NUM_PROC; p++) begin
            gap_r[p] <= '0;
         end
      end else begin
         for (int p = 0; p < NUM_PROC; p++) begin
            if (acc[p]) begin
               gap_r[p] <= (NOM_W+1)'(1);
            end else if (gap_r[p] != '1) begin
               gap_r[p] <= gap_r[p] + (NOM_W+1)'(1);
            end
         end
      end
   end

   // the first accepted stamp has no gap to judge, so it never errs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_r <= '0;
      end else begin
         seen_r <= seen_r | acc;
      end
   end

   logic [NOM_W:0] tol [NUM_PROC];
   logic [NUM_PROC-1:0] off_period;

   always_comb begin
      for (int p = 0; p < NUM_PROC; p++) begin
         tol[p] = (NOM_W+1)'(nom_r[p] >> TOL_SHIFT);
         // a zero nominal period turns the check off
         off_period[p] = seen_r[p] & (nom_r[p] != '0) &
            ((gap_r[p] > {1'b0, nom_r[p]} + tol[p]) ||
             (gap_r[p] + tol[p] < {1'b0, nom_r[p]}));
      end
   end

   // nco time already counts whole periods above a 40-bit fraction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int p = 0; p < NUM_PROC; p++) begin
            live_time_r[p] <= '0;
         end
      end else begin
         for (int p = 0; p < NUM_PROC; p++) begin
            if (acc[p]) begin
               live_time_r[p] <= base_time[p];
            end
         end
      end
   end

   // the flag travels with the stamp it was judged on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         live_err_r <= '0;
      end else begin
         for (int p = 0; p < NUM_PROC; p++) begin
            if (acc[p]) begin
               live_err_r[p] <= off_period[p];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // missed stamps

   logic [NUM_PROC-1:0] pend_r;
   logic [MISS_W-1:0] miss_r [NUM_PROC];

   // a stamp landing with the update strobe starts the next series
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_r <= '0;
      end else if (upd) begin
         pend_r <= acc;
      end else begin
         pend_r <= pend_r | acc;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int p = 0; p < NUM_PROC; p++) begin
            miss_r[p] <= '0;
         end
      end else begin
         for (int p = 0; p < NUM_PROC; p++) begin
            if (upd) begin
               miss_r[p] <= '0;
            end else if (acc[p] && pend_r[p] && miss_r[p] != MISS_MAX) begin
               miss_r[p] <= miss_r[p] + MISS_W'(1);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // snapshot for software

   logic [TIME_W-1:0] snap_time_r [NUM_PROC];
   logic [MISS_W-1:0] snap_miss_r [NUM_PROC];
   logic [NUM_PROC-1:0] snap_err_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int p = 0; p < NUM_PROC; p++) begin
            snap_time_r[p] <= '0;
         end
      end else if (upd) begin
         for (int p = 0; p < NUM_PROC; p++) begin
            snap_time_r[p] <= live_time_r[p];
         end
      end
   end

   // a refresh wins over a read clear landing in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int p = 0; p < NUM_PROC; p++) begin
            snap_miss_r[p] <= '0;
         end
      end else begin
         for (int p = 0; p < NUM_PROC; p++) begin
            if (upd) begin
               snap_miss_r[p] <= miss_r[p];
            end else if (rd_en && idx == (p == 0 ? IDX_MISS0 : IDX_MISS1)) begin
               snap_miss_r[p] <= '0;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         snap_err_r <= '0;
      end else if (upd) begin
         snap_err_r <= live_err_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event status and interrupt

   logic [7:0] status_r;
   logic [7:0] stat_set;
   logic [7:0] stat_clr;

   always_comb begin
      stat_set = '0;
      for (int p = 0; p < NUM_PROC; p++) begin
         stat_set[STAT_BIT0+p] = acc[p] & ~mask_r[STAT_BIT0+p];
      end
   end

   // write one to clear, limited to the two stamp bits
   always_comb begin
      stat_clr = 8'h00;
      if (wr_en && idx == IDX_STATUS) begin
         stat_clr = pwdata[7:0] & STAT_WMASK;
      end
   end

   // set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_r <= STAT_RST;
      end else begin
         status_r <= (status_r & ~stat_clr) | stat_set;
      end
   end

   assign irq = |status_r;

   ////////////////////////////////////////////////////////////////////////////
   // read data, registered in the setup cycle

   always_comb begin
      rd_data = '0;
      if (idx == IDX_CFG0) begin
         rd_data[7:0] = cfg_r[0];
      end else if (idx == IDX_CFG1) begin
         rd_data[7:0] = cfg_r[1];
      end else if (idx == IDX_NOM0) begin
         rd_data[NOM_W-1:0] = nom_r[0];
      end else if (idx == IDX_NOM1) begin
         rd_data[NOM_W-1:0] = nom_r[1];
      end else if (idx == IDX_STATUS) begin
         rd_data[7:0] = status_r;
      end else if (idx == IDX_MASK) begin
         rd_data[7:0] = mask_r;
      end else if (idx >= IDX_TIME0 && idx < IDX_MISS0) begin
         rd_data[7:0] = time_byte(snap_time_r[0], idx - IDX_TIME0);
      end else if (idx == IDX_MISS0) begin
         rd_data[MISS_W-1:0] = snap_miss_r[0];
      end else if (idx == IDX_ERR0) begin
         rd_data[ERR_BIT] = snap_err_r[0];
      end else if (idx >= IDX_TIME1 && idx < IDX_MISS1) begin
         rd_data[7:0] = time_byte(snap_time_r[1], idx - IDX_TIME1);
      end else if (idx == IDX_MISS1) begin
         rd_data[MISS_W-1:0] = snap_miss_r[1];
      end else if (idx == IDX_ERR1) begin
         rd_data[ERR_BIT] = snap_err_r[1];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         // misaligned or unmapped reads return zero alongside the error
         prdata <= hit ? rd_data : 32'h0000_0000;
      end
   end

endmodule : user_time_stamp_processor

// File: hdl/tsp_pkg.sv
// shared constants, field layouts and carriers of the user time stamp processors
package tsp_pkg;

   localparam int unsigned NUM_SRC = 11;
   localparam int unsigned NUM_PROC = 2;
   localparam int unsigned TIME_W = 80;
   localparam int unsigned FRAC_W = 40;
   localparam int unsigned MISS_W = 8;
   localparam int unsigned NOM_W = 16;
   localparam int unsigned TIME_BYTES = 10;

   // register indices; byte address is four times the index
   localparam logic [13:0] IDX_UPDATE = 14'h000f;
   localparam logic [13:0] IDX_CFG0 = 14'h2a12;
   localparam logic [13:0] IDX_CFG1 = 14'h2a13;
   localparam logic [13:0] IDX_NOM0 = 14'h2a18;
   localparam logic [13:0] IDX_NOM1 = 14'h2a19;
   localparam logic [13:0] IDX_STATUS = 14'h300f;
   localparam logic [13:0] IDX_MASK = 14'h3010;
   localparam logic [13:0] IDX_TIME0 = 14'h3a14;
   localparam logic [13:0] IDX_MISS0 = 14'h3a1e;
   localparam logic [13:0] IDX_ERR0 = 14'h3a1f;
   localparam logic [13:0] IDX_TIME1 = 14'h3a20;
   localparam logic [13:0] IDX_MISS1 = 14'h3a2a;
   localparam logic [13:0] IDX_ERR1 = 14'h3a2b;

   // field positions
   localparam int unsigned UPDATE_BIT = 0;
   localparam int unsigned STAT_BIT0 = 2;
   localparam int unsigned ERR_BIT = 0;
   localparam logic [7:0] CFG_WMASK = 8'hbf;
   localparam logic [7:0] STAT_WMASK = 8'h0c;

   // values after reset, missed-count limit and tolerance shift
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic [NOM_W-1:0] NOM_RST = 16'h0000;
   localparam logic [MISS_W-1:0] MISS_MAX = 8'hff;
   localparam int unsigned TOL_SHIFT = 2;

   // configuration byte: bit7 time base, bit6 reserved, bit5 tags only, 4:0 source
   typedef struct packed {
      logic tbase;
      logic rsvd;
      logic tag_only;
      logic [4:0] sel;
   } proc_cfg_type;

   typedef struct packed {
      logic [NUM_SRC-1:0] valid;
      logic [NUM_SRC-1:0] tag;
   } stamp_bus_type;

endpackage : tsp_pkg

// File: sim/tsp_props.sv
// port checker for the user time stamp processors
`timescale 1ns/1ps
module tsp_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire tsp_pkg::stamp_bus_type stamps,
   input wire logic irq
);
   import tsp_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic [13:0] idx = paddr[15:2];
   ////////////////////////////////////////////////////////////////
   sequence s_rd;
      psel && penable && !pwrite;
   endsequence
   property p_acc; pslverr |-> psel && penable; endproperty
   a_acc: assert property (p_acc) else $error("error outside access");
   property p_unmap; s_rd ##0 pslverr |-> prdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("refused read not zero");
   // registered read data may only move on a read setup
   property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_up; $rose(irq) |-> $past(|stamps.valid); endproperty
   a_up: assert property (p_up) else $error("irq without stamp");
   property p_down; $fell(irq) |-> $past(psel && penable && pwrite); endproperty
   a_down: assert property (p_down) else $error("irq fell without write");
   property p_upd; s_rd ##0 idx == IDX_UPDATE |-> prdata == 32'h0; endproperty
   a_upd: assert property (p_upd) else $error("update reads nonzero");
   property p_cfg;
      s_rd ##0 (idx == IDX_CFG0 || idx == IDX_CFG1) |-> prdata[31:8] == 24'h0 && !prdata[6];
   endproperty
   a_cfg: assert property (p_cfg) else $error("config extra bits");
   property p_flag;
      s_rd ##0 (idx == IDX_ERR0 || idx == IDX_ERR1) |-> prdata[31:1] == 31'h0;
   endproperty
   a_flag: assert property (p_flag) else $error("flag extra bits");
   property p_byte;
      s_rd ##0 idx >= IDX_TIME0 && idx <= IDX_ERR1 |-> prdata[31:8] == 24'h0;
   endproperty
   a_byte: assert property (p_byte) else $error("result byte too wide");
endmodule : tsp_props

bind user_time_stamp_processor tsp_props i_tsp_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .stamps(stamps), .irq(irq));

// File: sim/tb.sv
// self-checking bench for the user time stamp processors
`timescale 1ns/1ps
module tb;
   import tsp_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, serr;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [TIME_W-1:0] nco0_time, nco1_time;
   stamp_bus_type stamps;
   proc_cfg_type cfgm [2];
   logic [TIME_W-1:0] q [2][$];
   logic [TIME_W-1:0] snap_t [2];
   int snap_m [2], snap_e [2], err_m [2], lastc [2];
   int err_count = 0, checked = 0, seed = 42358, cyc = 0, stat = 0, mask = 0, nom = 0, s;
   user_time_stamp_processor i_user_time_stamp_processor (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .stamps(stamps),
      .nco0_time(nco0_time), .nco1_time(nco1_time), .irq(irq));
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   // counted on the far edge so stamp tasks read it race free
   always @(negedge pclk) cyc++;
   ////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask : chk
   task automatic apb(input logic w, input logic [13:0] i, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rv = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         err_count++;
         final_report();
      end
      @(posedge pclk);
   endtask : apb
   task automatic setcfg(input int p, input logic [7:0] v);
      apb(1'b1, p == 1 ? IDX_CFG1 : IDX_CFG0, {24'h0, v});
      cfgm[p] = v & CFG_WMASK;
   endtask : setcfg
   ////////////////////////////////////////////////////////////////
   task automatic pulse(input int s, input logic tg);
      stamp_bus_type v;
      logic [95:0] a, b;
      int d;
      a = {$random(seed), $random(seed), $random(seed)};
      b = {$random(seed), $random(seed), $random(seed)};
      v = '0;
      v.valid[s] = 1'b1;
      v.tag[s] = tg;
      stamps <= v;
      nco0_time <= a[79:0];
      nco1_time <= b[79:0];
      @(posedge pclk);
      for (int p = 0; p < 2; p++) begin
         if (cfgm[p].sel == s && (!cfgm[p].tag_only || tg)) begin
            q[p].push_back(cfgm[p].tbase ? b[79:0] : a[79:0]);
            d = cyc - lastc[p];
            err_m[p] = p == 0 && nom > 0 && lastc[p] >= 0 && (d < nom - nom / 4 || d > nom + nom / 4);
            lastc[p] = cyc;
            if (!mask[p + 2]) stat = stat | (4 << p);
         end
      end
      stamps <= '0;
      nco0_time <= ~a[79:0];
      nco1_time <= ~b[79:0];
      @(posedge pclk);
   endtask : pulse
   task automatic upd;
      apb(1'b1, IDX_UPDATE, 32'h1);
      for (int p = 0; p < 2; p++) begin
         snap_m[p] = 0;
         snap_e[p] = err_m[p];
         if (q[p].size() > 0) begin
            snap_t[p] = q[p][$];
            snap_m[p] = q[p].size() - 1;
         end
         q[p].delete();
      end
   endtask : upd
   task automatic res(input int p);
      logic [13:0] base;
      base = p == 1 ? IDX_TIME1 : IDX_TIME0;
      for (int k = 0; k < TIME_BYTES; k++) begin
         apb(1'b0, base + 14'(k), 32'h0);
         chk("time byte", {24'h0, snap_t[p][8*k+:8]}, rv);
      end
      apb(1'b0, base + 14'd10, 32'h0);
      chk("missed", snap_m[p], rv);
      snap_m[p] = 0;
      apb(1'b0, base + 14'd10, 32'h0);
      chk("missed reread", 32'h0, rv);
      apb(1'b0, base + 14'd11, 32'h0);
      chk("error flag", snap_e[p], rv);
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("status", stat, rv);
      chk("irq", {31'h0, stat != 0}, {31'h0, irq});
   endtask : res
   ////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      stamps = '0;
      nco0_time = '0;
      nco1_time = '0;
      cfgm = '{default: '0};
      lastc = '{-1, -1};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, IDX_CFG0, 32'h0);
      chk("cfg reset", {24'h0, CFG_RST}, rv);
      setcfg(1, 8'hff);
      apb(1'b0, IDX_CFG1, 32'h0);
      chk("cfg readback", {24'h0, CFG_WMASK}, rv);
      apb(1'b0, IDX_UPDATE, 32'h0);
      chk("update reads", 32'h0, rv);
      apb(1'b0, 14'h0100, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, serr});
      for (s = 0; s < NUM_SRC; s++) begin
         setcfg(s % 2, {s[1], 2'b00, s[4:0]});
         pulse((s + 1) % NUM_SRC, 1'b1);
         repeat (s % 3 + 1) pulse(s, 1'b0);
         upd();
         if (s == 0) begin
            pulse(s, 1'b0);
            apb(1'b1, IDX_TIME0, 32'hff);
         end
         res(s % 2);
         apb(1'b1, IDX_STATUS, 32'h0c);
         stat = 0;
      end
      setcfg(1, 8'h29);
      pulse(9, 1'b0);
      pulse(9, 1'b1);
      upd();
      res(1);
      apb(1'b1, IDX_STATUS, 32'h0c);
      stat = 0;
      apb(1'b1, IDX_MASK, 32'h04);
      mask = 4;
      setcfg(0, 8'h03);
      pulse(3, 1'b0);
      upd();
      res(0);
      apb(1'b1, IDX_MASK, 32'h0);
      mask = 0;
      apb(1'b1, IDX_NOM0, 32'd12);
      nom = 12;
      pulse(3, 1'b0);
      repeat (10) @(posedge pclk);
      pulse(3, 1'b0);
      upd();
      res(0);
      pulse(3, 1'b0);
      upd();
      res(0);
      final_report();
   end
endmodule : tb
